// *** rfp_pkg.sv ***
// rfp_pkg: constants and types shared by the fault protection block
package rfp_pkg;
	// register map
	localparam logic [7:0] EXIT_LAT_OFFSET = 8'h2B;
	localparam int EXIT_LAT_MANT_LSB = 0;
	localparam int EXIT_LAT_EXP_LSB = 4;
	localparam logic [7:0] EXIT_LAT_RESET = 8'h10;
	// voltages in millivolts, 12-bit codes in 1 mV units
	localparam int MV_W = 12;
	localparam logic [11:0] MARGIN_STEP_MV = 12'h032;
	localparam logic [11:0] UV_FIXED_MV = 12'h0F8;
	localparam logic [11:0] OV_RELEASE_MV = 12'h0F8;
	localparam logic [11:0] SS_OV_0_MV = 12'h9C4;
	localparam logic [11:0] SS_OV_1_MV = 12'h4B0;
	localparam logic [11:0] SS_OV_2_MV = 12'h4FB;
	localparam logic [11:0] SS_OV_3_MV = 12'h546;
	// current and temperature
	localparam logic [7:0] OC_MAX_A = 8'h3E;
	localparam logic [7:0] HOT_MIN_C = 8'h40;
	localparam logic [7:0] HOT_MAX_C = 8'h7F;
	localparam logic [7:0] OT_ADD_MAX_C = 8'h20;
	localparam logic [7:0] OT_CAP_C = 8'h87;
	localparam int TEMP_GAIN_UV_PER_C = 4880;
	// hiccup timing
	localparam int HICCUP_TIME_US = 1000;
	localparam int CLK_MHZ = 100;
	localparam int HICCUP_CYCLES = HICCUP_TIME_US * CLK_MHZ;
	localparam logic [1:0] HICCUP_RETRIES = 2'h2;
	// modes
	typedef enum logic [1:0] {RFP_OC_SHUTDOWN, RFP_OC_HICCUP2, RFP_OC_HICCUP_INF, RFP_OC_RSVD} rfp_oc_mode_t;
	typedef enum logic [1:0] {RFP_GANG_SINGLE, RFP_GANG_DOUBLER, RFP_GANG_QUAD, RFP_GANG_RSVD} rfp_gang_t;
	// sticky flag positions
	localparam int FLT_OT = 0;
	localparam int FLT_OC = 1;
	localparam int FLT_OV = 2;
	localparam int FLT_UV = 3;
	localparam int FLT_VIN_LOCK = 4;
	localparam int FLT_VCC_LOCK = 5;
	localparam int FLT_PHASE = 6;
	localparam int FLT_SLOW_OC = 7;
	localparam int FLT_W = 8;
endpackage

// *** rfp_slow_filter.sv ***
// rfp_slow_filter: first-order low-pass averager of the total current
module rfp_slow_filter #(
	parameter int W = 16,
	parameter int BASE_SHIFT = 16
) (
	// clocking
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// sample and setting
	input wire logic [W-1:0] sample,
	input wire logic [2:0] bw_code,
	// averaged result
	output logic [W-1:0] average
);
	import rfp_pkg::*;
	typedef struct packed {
		logic [W+BASE_SHIFT-1:0] acc;
	} rfp_flt_t;
	rfp_flt_t st, next_st;
	logic [4:0] shift;
	initial begin
		if (BASE_SHIFT < 8 || BASE_SHIFT > 24) $error("rfp_slow_filter: BASE_SHIFT out of range");
	end
	// each code step doubles the bandwidth by lowering the shift by one
	always_comb begin
		logic [W+BASE_SHIFT-1:0] ext;
		ext = '0;
		shift = 5'(BASE_SHIFT) - 5'(bw_code);
		next_st = st;
		ext[W+BASE_SHIFT-1:BASE_SHIFT] = sample;
		next_st.acc = st.acc - (st.acc >> shift) + (ext >> shift);
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end
	assign average = st.acc[W+BASE_SHIFT-1:BASE_SHIFT];
endmodule

// *** rfp_core.sv ***
// rfp_core: fault supervision and deepest power state handling
// How it works
// - deepest state: acknowledge, zero output, tristate PWM
// - wake on bus clock or set command
// - exit latency register: mantissa low, exponent high
// - sticky fault flags until clear or power
// - over-voltage flags fault, low-side switches on
// - option: latch low-side or release below level
// - release mode re-arms on renewed over-voltage
// - no over-voltage check during downward transition
// - soft-start over-voltage level from 2-bit code
// - over-voltage optionally active while disabled
// - shared margin code: 50 mV times n+1
// - under-voltage by margin or fixed 248 mV
// - under-voltage threshold optionally includes droop
// - under-voltage response follows over-current mode
// - over-current 0..62 A, scaled by gang mode
// - over-current modes: shutdown, hiccup twice, forever
// - current trips masked in start-up and transitions
// - slow limit compares filtered current to threshold
// - warning 64..127 C, trip adds 0..32, cap 135
// - over-temperature latches off until enable cycle
// - temperature arrives converted at fixed gain
// - stage fault high: shut down, raise catastrophic
module rfp_core #(
	parameter int HICCUP_DELAY = rfp_pkg::HICCUP_CYCLES,
	parameter int PHASES = 8,
	parameter logic [7:0] EXIT_LATENCY = rfp_pkg::EXIT_LAT_RESET
) (
	// clocking
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// enable and supply monitors (pins)
	input wire logic enable_pin,
	input wire logic vin_lockout_pin,
	input wire logic vcc_lockout_pin,
	input wire logic phase_fault_in,
	input wire logic [PHASES-1:0] stage_fault_pin,
	// voltage-ID bus events, already in this clock domain
	input wire logic vid_bus_clk_seen,
	input wire logic deep_state_cmd,
	input wire logic set_cmd,
	input wire logic [7:0] vid_reg_addr,
	output logic [7:0] vid_reg_rdata,
	output logic deep_state_ack,
	// loop status
	input wire logic soft_start,
	input wire logic vid_transition,
	input wire logic vid_down,
	input wire logic [11:0] vout_mv,
	input wire logic [11:0] vid_setpoint_mv,
	input wire logic [11:0] droop_mv,
	input wire logic [15:0] total_current_a,
	input wire logic [7:0] max_phase_current_a,
	input wire logic [7:0] temp_sense_input,
	// configuration
	input wire logic deep_state_ramp_select,
	input wire logic wake_on_clock,
	input wire logic overvolt_latch_mode,
	input wire logic overvolt_active_when_off,
	input wire logic [1:0] soft_start_ov_code,
	input wire logic [2:0] margin_code,
	input wire logic uv_use_converter,
	input wire logic uv_include_droop,
	input wire logic [7:0] oc_limit_a,
	input wire rfp_pkg::rfp_gang_t gang_mode,
	input wire rfp_pkg::rfp_oc_mode_t oc_mode,
	input wire logic [15:0] slow_oc_limit_a,
	input wire logic [2:0] telemetry_bw,
	input wire logic [7:0] hot_limit_c,
	input wire logic [5:0] ot_add_c,
	input wire logic clear_sticky,
	// outputs
	output logic regulator_on,
	output logic ramp_to_zero,
	output logic pwm_tristate,
	output logic low_side_on,
	output logic thermal_warning_flag,
	output logic catastrophic_fault_out,
	output logic [rfp_pkg::FLT_W-1:0] live_faults,
	output logic [rfp_pkg::FLT_W-1:0] sticky_faults
);
	import rfp_pkg::*;
	typedef enum logic [1:0] {RFP_RUN, RFP_DEEP, RFP_HICCUP, RFP_OFF} rfp_state_t;
	typedef struct packed {
		logic [1:0] en_s;
		logic [1:0] vin_s;
		logic [1:0] vcc_s;
		logic [1:0] ph_s;
		logic [PHASES-1:0] stg_s1;
		logic [PHASES-1:0] stg_s2;
		rfp_state_t state;
		logic [31:0] timer;
		logic [1:0] trips;
		logic ov_hold;
		logic ack;
		logic ramp;
		logic cat;
		logic [FLT_W-1:0] sticky;
		logic [7:0] rdata;
	} rfp_st_t;
	rfp_st_t st, next_st;
	logic en_q, vin_q, vcc_q, ph_q, stage_any;
	logic [11:0] margin, ov_level, uv_level;
	logic [9:0] oc_scaled;
	logic [7:0] ot_level, hot_level;
	logic [8:0] ot_sum;
	logic ov_armed, ov_now, uv_now, oc_now, slow_now, ot_now, ilim_mask;
	logic [15:0] slow_avg;
	logic [FLT_W-1:0] live;
	initial begin
		if (HICCUP_DELAY < 1) $error("rfp_core: HICCUP_DELAY must be positive");
		if (PHASES < 1 || PHASES > 16) $error("rfp_core: PHASES out of range");
	end
	// synchroniser second stages
	assign en_q = st.en_s[1];
	assign vin_q = st.vin_s[1];
	assign vcc_q = st.vcc_s[1];
	assign ph_q = st.ph_s[1];
	assign stage_any = |st.stg_s2;
	// averaged current for the slow limit
	rfp_slow_filter #(.W(16), .BASE_SHIFT(16)) u_slow (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.sample(total_current_a),
		.bw_code(telemetry_bw),
		.average(slow_avg)
	);
	// thresholds
	always_comb begin
		margin = 12'(MARGIN_STEP_MV * ({9'h000, margin_code} + 12'h001));
		case (soft_start_ov_code)
			2'h0: ov_level = SS_OV_0_MV;
			2'h1: ov_level = SS_OV_1_MV;
			2'h2: ov_level = SS_OV_2_MV;
			default: ov_level = SS_OV_3_MV;
		endcase
		if (!soft_start) begin
			ov_level = vid_setpoint_mv + margin;
		end
		if (uv_use_converter) begin
			uv_level = UV_FIXED_MV;
		end else begin
			uv_level = (vid_setpoint_mv > margin) ? vid_setpoint_mv - margin : 12'h000;
			if (uv_include_droop) begin
				uv_level = (uv_level > droop_mv) ? uv_level - droop_mv : 12'h000;
			end
		end
		case (gang_mode)
			RFP_GANG_DOUBLER: oc_scaled = {1'b0, (oc_limit_a > OC_MAX_A ? OC_MAX_A : oc_limit_a), 1'b0};
			RFP_GANG_QUAD: oc_scaled = {(oc_limit_a > OC_MAX_A ? OC_MAX_A : oc_limit_a), 2'b00};
			default: oc_scaled = {2'b00, (oc_limit_a > OC_MAX_A ? OC_MAX_A : oc_limit_a)};
		endcase
		// warning level clamped once, shared by the flag and the trip level
		hot_level = (hot_limit_c < HOT_MIN_C) ? HOT_MIN_C : ((hot_limit_c > HOT_MAX_C) ? HOT_MAX_C : hot_limit_c);
		ot_sum = {1'b0, hot_level} + {1'b0, ((8'(ot_add_c) > OT_ADD_MAX_C) ? OT_ADD_MAX_C : 8'(ot_add_c))};
		ot_level = (ot_sum > {1'b0, OT_CAP_C}) ? OT_CAP_C : ot_sum[7:0];
	end
	// detectors
	always_comb begin
		ov_armed = (en_q || overvolt_active_when_off) && !vid_down;
		ov_now = ov_armed && (vout_mv > ov_level);
		uv_now = en_q && !soft_start && !vid_transition && st.state == RFP_RUN && (vout_mv < uv_level);
		ilim_mask = soft_start || vid_transition;
		oc_now = !ilim_mask && st.state == RFP_RUN && ({2'b00, max_phase_current_a} > oc_scaled);
		slow_now = !ilim_mask && st.state == RFP_RUN && (slow_avg > slow_oc_limit_a);
		ot_now = temp_sense_input > ot_level; // input is already in degrees
		live = '0;
		live[FLT_OT] = ot_now;
		live[FLT_OC] = oc_now;
		live[FLT_OV] = ov_now;
		live[FLT_UV] = uv_now;
		live[FLT_VIN_LOCK] = vin_q;
		live[FLT_VCC_LOCK] = vcc_q;
		live[FLT_PHASE] = ph_q;
		live[FLT_SLOW_OC] = slow_now;
	end
	// next state
	always_comb begin
		next_st = st;
		next_st.en_s = {st.en_s[0], enable_pin};
		next_st.vin_s = {st.vin_s[0], vin_lockout_pin};
		next_st.vcc_s = {st.vcc_s[0], vcc_lockout_pin};
		next_st.ph_s = {st.ph_s[0], phase_fault_in};
		next_st.stg_s1 = stage_fault_pin;
		next_st.stg_s2 = st.stg_s1;
		next_st.ack = 1'b0;
		next_st.sticky = (clear_sticky ? '0 : st.sticky) | live; // set wins
		next_st.rdata = (vid_reg_addr == EXIT_LAT_OFFSET) ? EXIT_LATENCY : 8'h00;
		// low-side hold: latched until reset or until below release level
		if (ov_now) begin
			next_st.ov_hold = 1'b1;
		end else if (!overvolt_latch_mode && vout_mv < OV_RELEASE_MV) begin
			next_st.ov_hold = 1'b0;
		end
		if (stage_any) begin
			next_st.cat = 1'b1;
		end
		if (st.timer != 32'h0) begin
			next_st.timer = st.timer - 32'h1;
		end
		case (st.state)
			RFP_RUN: begin
				if (stage_any || ot_now || ph_q) begin
					next_st.state = RFP_OFF;
				end else if (oc_now || slow_now || uv_now) begin
					if (oc_mode == RFP_OC_SHUTDOWN || (oc_mode == RFP_OC_HICCUP2 && st.trips == HICCUP_RETRIES)) begin
						next_st.state = RFP_OFF;
					end else begin
						next_st.state = RFP_HICCUP;
						next_st.timer = 32'(HICCUP_DELAY);
						if (st.trips != HICCUP_RETRIES) begin
							next_st.trips = st.trips + 2'h1;
						end
					end
				end else if (deep_state_cmd && en_q) begin
					next_st.state = RFP_DEEP;
					next_st.ack = 1'b1;
					next_st.ramp = deep_state_ramp_select;
				end
			end
			RFP_DEEP: begin
				if (stage_any || ot_now) begin
					next_st.state = RFP_OFF;
				end else if (wake_on_clock ? vid_bus_clk_seen : set_cmd) begin
					next_st.state = RFP_RUN;
				end
			end
			RFP_HICCUP: begin
				if (stage_any || ot_now) begin
					next_st.state = RFP_OFF;
				end else if (st.timer == 32'h0) begin
					next_st.state = RFP_RUN;
				end
			end
			RFP_OFF: begin
				next_st.state = RFP_OFF;
			end
			default: next_st.state = RFP_OFF;
		endcase
		// an enable cycle restarts the state, retry count, timer and catastrophic flag
		if (!en_q) begin
			next_st.state = RFP_RUN;
			next_st.trips = 2'h0;
			next_st.cat = 1'b0;
			next_st.timer = 32'h0;
		end
	end
	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end
	// outputs
	assign regulator_on = en_q && st.state == RFP_RUN && !st.ov_hold;
	assign ramp_to_zero = st.state == RFP_DEEP && st.ramp;
	assign pwm_tristate = st.state == RFP_DEEP && !st.ov_hold;
	assign low_side_on = st.ov_hold;
	assign thermal_warning_flag = temp_sense_input > hot_level;
	assign catastrophic_fault_out = st.cat;
	assign live_faults = live;
	assign sticky_faults = st.sticky;
	assign deep_state_ack = st.ack;
	assign vid_reg_rdata = st.rdata;
	// checks
	property p_ack_enters_deep;
		@(posedge core_clk) disable iff (!rst_n) deep_state_ack |-> st.state == RFP_DEEP;
	endproperty
	a_ack_enters_deep: assert property (p_ack_enters_deep) else $error("ack without deep state");
	property p_latency_read;
		@(posedge core_clk) disable iff (!rst_n) clk_en && vid_reg_addr == EXIT_LAT_OFFSET |=> vid_reg_rdata == EXIT_LATENCY;
	endproperty
	a_latency_read: assert property (p_latency_read) else $error("latency register wrong");
	property p_sticky_holds;
		@(posedge core_clk) disable iff (!rst_n) clk_en && live_faults[FLT_OV] |=> sticky_faults[FLT_OV];
	endproperty
	a_sticky_holds: assert property (p_sticky_holds) else $error("sticky flag lost");
	property p_ov_low_side;
		@(posedge core_clk) disable iff (!rst_n) clk_en && ov_now |=> low_side_on;
	endproperty
	a_ov_low_side: assert property (p_ov_low_side) else $error("low side not on");
	property p_ov_latched;
		@(posedge core_clk) disable iff (!rst_n) overvolt_latch_mode && low_side_on && en_q |=> low_side_on;
	endproperty
	a_ov_latched: assert property (p_ov_latched) else $error("latched low side released");
	property p_no_ov_down;
		@(posedge core_clk) disable iff (!rst_n) vid_down |-> !live_faults[FLT_OV];
	endproperty
	a_no_ov_down: assert property (p_no_ov_down) else $error("ov during down transition");
	property p_oc_masked;
		@(posedge core_clk) disable iff (!rst_n) (soft_start || vid_transition) |-> !live_faults[FLT_OC] && !live_faults[FLT_SLOW_OC];
	endproperty
	a_oc_masked: assert property (p_oc_masked) else $error("current trip not masked");
	property p_ot_cap;
		@(posedge core_clk) disable iff (!rst_n) ot_level <= OT_CAP_C && ot_level >= HOT_MIN_C;
	endproperty
	a_ot_cap: assert property (p_ot_cap) else $error("trip level out of range");
	property p_stage_cat;
		@(posedge core_clk) disable iff (!rst_n) clk_en && stage_any && en_q |=> catastrophic_fault_out && st.state == RFP_OFF;
	endproperty
	a_stage_cat: assert property (p_stage_cat) else $error("stage fault not handled");
endmodule

// *** rfp_stage_model.sv ***
// rfp_stage_model: power stages that report a fault as a high level
module rfp_stage_model #(
	parameter int PHASES = 8
) (
	// clocking
	input wire logic core_clk,
	// fault request from the bench
	input wire logic fail_req,
	input wire logic [2:0] fail_phase,
	// fault pins toward the controller
	output logic [PHASES-1:0] stage_fault_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// a faulted stage holds its pin high while asked to
	always_ff @(posedge core_clk) begin
		stage_fault_pin <= '0;
		if (fail_req) begin
			stage_fault_pin[fail_phase] <= 1'b1;
		end
	end
endmodule

// *** testbench.sv ***
// testbench: self-checking bench for the fault protection core
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import rfp_pkg::*;
	localparam logic [7:0] EXIT_LAT = 8'hA5;
	logic core_clk, rst_n, clk_en, enable_pin, vin_lockout_pin, vcc_lockout_pin, phase_fault_in;
	logic vid_bus_clk_seen, deep_state_cmd, set_cmd, soft_start, vid_transition, vid_down;
	logic deep_state_ramp_select, wake_on_clock, overvolt_latch_mode, overvolt_active_when_off;
	logic uv_use_converter, uv_include_droop, clear_sticky, fail_req, prev;
	logic regulator_on, ramp_to_zero, pwm_tristate, low_side_on, thermal_warning_flag;
	logic catastrophic_fault_out, deep_state_ack;
	logic [7:0] stage_fault_pin, vid_reg_addr, vid_reg_rdata, max_phase_current_a;
	logic [7:0] temp_sense_input, oc_limit_a, hot_limit_c, r;
	logic [11:0] vout_mv, vid_setpoint_mv, droop_mv;
	logic [15:0] total_current_a, slow_oc_limit_a;
	logic [1:0] soft_start_ov_code;
	logic [2:0] margin_code, telemetry_bw, fail_phase;
	logic [5:0] ot_add_c;
	logic [FLT_W-1:0] live_faults, sticky_faults;
	rfp_gang_t gang_mode;
	rfp_oc_mode_t oc_mode;
	int num_errors, samples_checked, rises;
	// clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	rfp_stage_model #(.PHASES(8)) u_stage (.core_clk, .fail_req, .fail_phase, .stage_fault_pin);
	rfp_core #(.HICCUP_DELAY(8), .PHASES(8), .EXIT_LATENCY(EXIT_LAT)) u_dut (.core_clk, .rst_n, .clk_en,
		.enable_pin, .vin_lockout_pin, .vcc_lockout_pin, .phase_fault_in, .stage_fault_pin,
		.vid_bus_clk_seen, .deep_state_cmd, .set_cmd, .vid_reg_addr, .vid_reg_rdata, .deep_state_ack,
		.soft_start, .vid_transition, .vid_down, .vout_mv, .vid_setpoint_mv, .droop_mv, .total_current_a,
		.max_phase_current_a, .temp_sense_input, .deep_state_ramp_select, .wake_on_clock,
		.overvolt_latch_mode, .overvolt_active_when_off, .soft_start_ov_code, .margin_code,
		.uv_use_converter, .uv_include_droop, .oc_limit_a, .gang_mode, .oc_mode, .slow_oc_limit_a,
		.telemetry_bw, .hot_limit_c, .ot_add_c, .clear_sticky, .regulator_on, .ramp_to_zero,
		.pwm_tristate, .low_side_on, .thermal_warning_flag, .catastrophic_fault_out, .live_faults,
		.sticky_faults);
	// random source
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// expected restarts seen in a long trip for each mode, capped at 3
	function automatic logic [15:0] exp_rises(input int m);
		return (m == 0) ? 16'h0000 : (m == 1) ? 16'h0002 : 16'h0003;
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// bounded wait for the regulator to run
	task automatic wait_on();
		int i;
		i = 0;
		while (regulator_on !== 1'b1 && i < 100) begin
			step(1);
			i++;
		end
		if (i == 100) begin
			chk("start timeout", 16'h0001, 16'h0000);
			give_verdict();
		end
	endtask
	task automatic restart();
		enable_pin = 1'b0;
		step(4);
		enable_pin = 1'b1;
		wait_on();
	endtask
	// one-cycle bus event: 0 deep, 1 set, 2 clock
	task automatic pulse(input int k);
		{vid_bus_clk_seen, set_cmd, deep_state_cmd} = 3'b001 << k;
		step(1);
		{vid_bus_clk_seen, set_cmd, deep_state_cmd} = 3'b000;
	endtask
	task automatic end_test(input string n);
		$display("test %s done, %0d checks", n, samples_checked);
	endtask
	initial begin
		{rst_n, vin_lockout_pin, vcc_lockout_pin, phase_fault_in, fail_req, fail_phase} = '0;
		{vid_bus_clk_seen, deep_state_cmd, set_cmd, soft_start, vid_transition, vid_down} = '0;
		{deep_state_ramp_select, wake_on_clock, overvolt_latch_mode, overvolt_active_when_off} = '0;
		{uv_use_converter, uv_include_droop, clear_sticky, vid_reg_addr, margin_code} = '0;
		{clk_en, enable_pin, vid_setpoint_mv, vout_mv} = {2'b11, 12'h3E8, 12'h3E8};
		{oc_limit_a, max_phase_current_a, hot_limit_c, ot_add_c} = {8'h1E, 8'h0A, 8'h50, 6'h05};
		{temp_sense_input, total_current_a, slow_oc_limit_a} = {8'h19, 16'h0040, 16'hFFFF};
		r = 8'h63;
		{droop_mv, telemetry_bw, soft_start_ov_code} = {4'h0, r, r[4:0]};
		gang_mode = RFP_GANG_SINGLE;
		oc_mode = RFP_OC_HICCUP_INF;
		step(2);
		rst_n = 1'b1;
		wait_on();
		// exit latency register and other addresses
		for (int i = 0; i < 4; i++) begin
			r = lfsr(r);
			vid_reg_addr = (i == 0) ? EXIT_LAT_OFFSET : r;
			step(1);
			chk("rdata", (vid_reg_addr == EXIT_LAT_OFFSET) ? EXIT_LAT : 8'h00, vid_reg_rdata);
		end
		end_test("register");
		// deepest state entry and both wake choices
		for (int w = 0; w < 2; w++) begin
			{wake_on_clock, deep_state_ramp_select} = {2{w[0]}};
			pulse(0);
			chk("ack", 16'h0001, deep_state_ack);
			chk("tristate", 16'h0001, pwm_tristate);
			chk("ramp", 16'(w), ramp_to_zero);
			step(1);
			pulse(w ? 1 : 2);
			step(2);
			chk("asleep", 16'h0001, pwm_tristate);
			pulse(w ? 2 : 1);
			step(2);
			chk("awake", 16'h0000, pwm_tristate);
			wait_on();
		end
		end_test("deep state");
		// current trips masked during a transition
		{vid_transition, max_phase_current_a} = {1'b1, 8'h3E};
		step(20);
		chk("oc masked", 16'h0001, regulator_on);
		{vid_transition, max_phase_current_a} = {1'b0, oc_limit_a};
		step(5);
		chk("oc at limit", 16'h0001, regulator_on);
		// quad gang scales the per-phase limit by four
		gang_mode = RFP_GANG_QUAD;
		max_phase_current_a = {oc_limit_a[5:0], 2'b00};
		step(5);
		chk("oc quad limit", 16'h0001, regulator_on);
		max_phase_current_a++;
		step(2);
		chk("oc quad trip", 16'h0000, regulator_on);
		gang_mode = RFP_GANG_SINGLE;
		max_phase_current_a = oc_limit_a;
		wait_on();
		// each over-current mode under a lasting trip
		for (int m = 0; m < 3; m++) begin
			oc_mode = rfp_oc_mode_t'(m);
			max_phase_current_a = oc_limit_a + 8'h01;
			{rises, prev} = {32'h0, 1'b1};
			for (int c = 0; c < 200; c++) begin
				step(1);
				rises += (regulator_on === 1'b1 && prev === 1'b0);
				prev = regulator_on;
			end
			chk("rises", exp_rises(m), (rises > 3) ? 16'h0003 : 16'(rises));
			chk("oc sticky", 16'h0001, sticky_faults[FLT_OC]);
			max_phase_current_a = oc_limit_a;
			step(30);
			chk("after oc", 16'(m == 2), regulator_on);
			restart();
		end
		end_test("over-current");
		// over-voltage: down transition, margin edge, trip, release, re-arm
		{overvolt_active_when_off, vid_transition, vid_down} = 3'b111;
		r = lfsr(r);
		margin_code = r[2:0];
		vout_mv = vid_setpoint_mv + 12'h300;
		step(3);
		chk("ov in dvid", 16'h0000, low_side_on);
		{vid_transition, vid_down} = 2'b00;
		vout_mv = vid_setpoint_mv + MARGIN_STEP_MV * (margin_code + 12'h001);
		step(3);
		chk("ov edge", 16'h0000, live_faults[FLT_OV]);
		vout_mv++;
		step(3);
		chk("ov flag", 16'h0001, live_faults[FLT_OV]);
		chk("low side", 16'h0001, low_side_on);
		vout_mv = OV_RELEASE_MV - 12'h001;
		step(3);
		chk("release", 16'h0000, low_side_on);
		vout_mv = vid_setpoint_mv + 12'h200;
		step(3);
		chk("re-arm", 16'h0001, low_side_on);
		vout_mv = 12'h0F0;
		step(3);
		// soft-start trip level from the code, not the setpoint
		{soft_start, soft_start_ov_code, vout_mv} = {1'b1, 2'h3, SS_OV_3_MV};
		step(2);
		chk("soft-start edge", 16'h0000, live_faults[FLT_OV]);
		vout_mv++;
		step(2);
		chk("soft-start ov", 16'h0001, live_faults[FLT_OV]);
		{soft_start, vout_mv} = {1'b0, 12'h0F0};
		step(3);
		vout_mv = vid_setpoint_mv;
		chk("ov sticky", 16'h0001, sticky_faults[FLT_OV]);
		clear_sticky = 1'b1;
		step(2);
		clear_sticky = 1'b0;
		chk("cleared", 16'h0000, sticky_faults);
		// latched mode holds the low side below the release level
		{overvolt_latch_mode, vout_mv} = {1'b1, vid_setpoint_mv + 12'h200};
		step(3);
		vout_mv = 12'h0F0;
		step(3);
		chk("latched", 16'h0001, low_side_on);
		{rst_n, enable_pin, overvolt_latch_mode} = 3'b000;
		step(2);
		rst_n = 1'b1;
		for (int a = 0; a < 2; a++) begin
			overvolt_active_when_off = a[0];
			vout_mv = vid_setpoint_mv + 12'h200;
			step(4);
			chk("ov when off", 16'(a), low_side_on);
			vout_mv = 12'h0F0;
			step(3);
		end
		vout_mv = vid_setpoint_mv;
		restart();
		end_test("over-voltage");
		// warning at the trip level, then over-temperature latches off
		temp_sense_input = 8'h55;
		step(3);
		chk("warning", 16'h0001, thermal_warning_flag);
		chk("on at trip", 16'h0001, regulator_on);
		temp_sense_input = 8'h56;
		step(3);
		chk("ot off", 16'h0000, regulator_on);
		temp_sense_input = 8'h19;
		step(20);
		chk("ot held", 16'h0000, regulator_on);
		restart();
		end_test("temperature");
		// under-voltage: fixed level, shutdown mode, droop-lowered level
		oc_mode = RFP_OC_SHUTDOWN;
		{uv_use_converter, vout_mv} = {1'b1, UV_FIXED_MV};
		step(3);
		chk("uv at level", 16'h0001, regulator_on);
		vout_mv = UV_FIXED_MV - 12'h001;
		step(20);
		chk("uv shutdown", 16'h0000, regulator_on);
		{uv_use_converter, uv_include_droop} = 2'b01;
		vout_mv = vid_setpoint_mv - MARGIN_STEP_MV * (margin_code + 12'h001) - droop_mv;
		restart();
		step(3);
		chk("uv droop level", 16'h0001, regulator_on);
		vout_mv--;
		step(3);
		chk("uv below droop", 16'h0000, regulator_on);
		{uv_include_droop, vout_mv} = {1'b0, vid_setpoint_mv};
		restart();
		end_test("under-voltage");
		// slow limit: averaged current crosses a low threshold
		{telemetry_bw, slow_oc_limit_a} = {3'h7, 16'h0020};
		for (int c = 0; c < 1000 && regulator_on === 1'b1; c++) begin
			step(1);
		end
		chk("slow oc", 16'h0001, sticky_faults[FLT_SLOW_OC]);
		chk("slow off", 16'h0000, regulator_on);
		slow_oc_limit_a = 16'hFFFF;
		restart();
		end_test("slow limit");
		// power stage fault
		r = lfsr(r);
		{fail_phase, fail_req} = {r[2:0], 1'b1};
		step(6);
		chk("catastrophic", 16'h0001, catastrophic_fault_out);
		chk("stage off", 16'h0000, regulator_on);
		end_test("stage fault");
		give_verdict();
	end
endmodule
